// File: serial_cfg_pkg.sv
`default_nettype none

package serial_cfg_pkg;

  ////////////////////////////////////////////////////////////////////////////
  // Addressing and command byte layout

  // Own address byte with the write bit, and its seven address bits
  localparam logic [7:0] SLAVE_ADDR_BYTE = 8'hD2;
  localparam logic [6:0] SLAVE_ADDR7 = SLAVE_ADDR_BYTE[7:1];
  // Command byte: mode bit, chip-select field, byte offset field
  localparam int CMD_MODE_BIT = 7;
  localparam int CMD_CS_HI = 6;
  localparam int CMD_CS_LO = 5;
  localparam int CMD_OFS_HI = 4;
  localparam int CMD_OFS_LO = 0;
  // Chip-select value that selects this device
  localparam logic [1:0] CHIP_SEL_VALUE = 2'h0;

  ////////////////////////////////////////////////////////////////////////////
  // Register bank

  // Number of implemented control bytes
  localparam int NUM_BYTES = 8;
  // Byte count returned first in a block read
  localparam logic [7:0] BLOCK_COUNT = 8'h08;
  // Byte indices that carry live fields
  localparam int CTRL0_IDX = 0;
  localparam int CTRL2_IDX = 2;
  localparam int CTRL6_IDX = 6;
  localparam int ID_IDX = 7;
  // Field positions
  localparam int OUT2_EN_BIT = 4;
  localparam int OUT1_EN_BIT = 3;
  localparam int SS_DEPTH_BIT = 7;
  localparam int SS_EN_BIT = 2;
  localparam int TEST_SEL_BIT = 7;
  localparam int TEST_MODE_BIT = 6;

  // Whole bank, byte 0 in the low lane
  typedef logic [NUM_BYTES-1:0][7:0] reg_bank_t;

  // Power-up values; the top byte is replaced by the identity byte
  localparam reg_bank_t REG_RESET = {8'h00, 8'h13, 8'h00, 8'h01,
                                     8'hAF, 8'hEA, 8'h00, 8'h7C};

  ////////////////////////////////////////////////////////////////////////////
  // Timing

  // Fastest bus clock served, and our own clock rate
  localparam int BUS_KHZ_MAX = 400;
  localparam int CLK_HZ = 20000000;
  // Own clock cycles in one half period of the fastest bus clock
  localparam int CYCLES_PER_HALF = CLK_HZ / (BUS_KHZ_MAX * 1000 * 2);
  // Least oversampling that the edge detector can serve
  localparam int MIN_CYCLES_PER_HALF = 4;

  ////////////////////////////////////////////////////////////////////////////
  // Carriers

  // Synchronised line levels and conditions, all one-cycle pulses but levels
  typedef struct packed {
    logic scl;
    logic sda;
    logic scl_rise;
    logic scl_fall;
    logic start;
    logic stop;
  } bus_events_t;

  // One byte write into the bank
  typedef struct packed {
    logic en;
    logic [2:0] idx;
    logic [7:0] data;
  } reg_write_t;

  // Protocol states of the serial slave
  typedef enum logic [3:0] {
    ST_IDLE,
    ST_ADDR,
    ST_ADDR_ACK,
    ST_CMD,
    ST_CMD_ACK,
    ST_WDATA,
    ST_WDATA_ACK,
    ST_RDATA,
    ST_RACK,
    ST_RNEXT,
    ST_IGNORE
  } slave_state_t;

  // Whole state of the serial slave
  typedef struct packed {
    slave_state_t st;
    logic [7:0] shift;
    logic [3:0] bitcnt;
    logic rw;
    logic block;
    logic count_phase;
    logic [4:0] ptr;
    logic oe;
    logic busy;
    reg_write_t wr;
  } port_state_t;

endpackage

`default_nettype wire

// File: bus_line_sync.sv
`timescale 1ns/1ps
`default_nettype none

module bus_line_sync
  import serial_cfg_pkg::*;
(
  input wire logic clk,
  input wire logic sys_rst,
  input wire logic scl_pin,
  input wire logic sda_pin,
  output bus_events_t ev
);

  // Pipeline: meta -> stable -> prev, events registered
  typedef struct packed {
    logic [1:0] meta;
    logic [1:0] stable;
    logic [1:0] prev;
    bus_events_t ev;
  } sync_state_t;

  sync_state_t q, d;

  ////////////////////////////////////////////////////////////////////////////
  // Next state: shift the lines in and derive conditions from stable/prev
  always_comb begin
    d = q;
    d.meta = {scl_pin, sda_pin};
    d.stable = q.meta;
    d.prev = q.stable;
    d.ev.scl = q.stable[1];
    d.ev.sda = q.stable[0];
    d.ev.scl_rise = q.stable[1] & ~q.prev[1];
    d.ev.scl_fall = ~q.stable[1] & q.prev[1];
    // Data falls while clock stays high
    d.ev.start = q.stable[1] & q.prev[1] & q.prev[0] & ~q.stable[0];
    // Data rises while clock stays high
    d.ev.stop = q.stable[1] & q.prev[1] & ~q.prev[0] & q.stable[0];
  end

  // State register; idle bus reads as both lines high
  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      q <= '{meta: 2'h3, stable: 2'h3, prev: 2'h3,
             ev: '{scl: 1'b1, sda: 1'b1, default: 1'b0}};
    end else begin
      q <= d;
    end
  end

  assign ev = q.ev;

endmodule

`default_nettype wire

// File: config_bank.sv
`timescale 1ns/1ps
`default_nettype none

module config_bank
  import serial_cfg_pkg::*;
#(
  parameter logic [7:0] ID_BYTE = 8'h5A
)
(
  input wire logic clk,
  input wire logic sys_rst,
  input reg_write_t wr,
  output reg_bank_t bank,
  output logic out1_en,
  output logic out2_en,
  output logic ss_en,
  output logic ss_depth,
  output logic test_mode,
  output logic test_sel
);

  // All bytes held in flip-flops
  typedef struct packed {
    reg_bank_t bank;
  } bank_state_t;

  bank_state_t q, d;

  ////////////////////////////////////////////////////////////////////////////
  // Byte write; the identity byte is read-only
  always_comb begin
    d = q;
    if (wr.en && (wr.idx != 3'(ID_IDX))) begin
      d.bank[wr.idx] = wr.data;
    end
    d.bank[ID_IDX] = ID_BYTE;
  end

  // Power-up defaults load on reset
  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      q.bank <= {ID_BYTE, REG_RESET[NUM_BYTES-2:0]};
    end else begin
      q <= d;
    end
  end

  // Fields straight from the byte flip-flops
  assign bank = q.bank;
  assign out1_en = q.bank[CTRL0_IDX][OUT1_EN_BIT];
  assign out2_en = q.bank[CTRL0_IDX][OUT2_EN_BIT];
  assign ss_en = q.bank[CTRL2_IDX][SS_EN_BIT];
  assign ss_depth = q.bank[CTRL2_IDX][SS_DEPTH_BIT];
  assign test_mode = q.bank[CTRL6_IDX][TEST_MODE_BIT];
  assign test_sel = q.bank[CTRL6_IDX][TEST_SEL_BIT];

endmodule

`default_nettype wire

// File: serial_config_port.sv
// Behaviour
// - Answer only the fixed address byte D2h
// - Command bit 7: zero block, one single
// - Bits 4:0 offset; zero for block transfers
// - Block bytes ascend from offset zero, MSB first
// - Block may end after any whole byte
// - Registers take defaults at power-up
// - Block write: address, command, count, data, stop
// - Block read: command, repeated start, read address
// - Read returns count then data; last unacknowledged
// - Single write: address, command, one data byte
// - Single read: command, restart, one byte, no-ack
// - Spread on/off and depth set by software
// - Each output pair enabled separately
// - Serve bus clock up to 400kHz
`timescale 1ns/1ps
`default_nettype none

module serial_config_port
  import serial_cfg_pkg::*;
#(
  // Identity byte; the value is arbitrary
  parameter logic [7:0] ID_BYTE = 8'h5A
)
(
  input wire logic clk,
  input wire logic sys_rst,
  input wire logic serial_bus_clock_pin,
  input wire logic serial_bus_data_pin_in,
  output logic serial_bus_data_pin_out,
  output logic serial_bus_data_pin_oe,
  output logic clock_out1_enable,
  output logic clock_out2_enable,
  output logic spread_enable,
  output logic spread_depth_sel,
  output logic test_mode_enable,
  output logic test_ref_select,
  output logic port_busy
);

  ////////////////////////////////////////////////////////////////////////////
  // Elaboration checks

  // The edge detector needs several own cycles per bus clock half
  if (CYCLES_PER_HALF < MIN_CYCLES_PER_HALF) begin : g_rate_check
    $error("Own clock too slow for the fastest bus clock");
  end

  // Bank index is three bits wide, so at most eight bytes
  if (NUM_BYTES > 8) begin : g_bank_check
    $error("Register bank larger than its index can reach");
  end

  ////////////////////////////////////////////////////////////////////////////
  // Signals

  // Synchronised lines and bus conditions
  bus_events_t ev;
  // Current bank contents for readback
  reg_bank_t bank;
  // Slave state and its next value
  port_state_t q, d;
  // Byte offered next on a read
  logic [7:0] tx_byte;
  // Pointer after the current read byte
  logic [4:0] next_ptr;
  // First byte offered after a read address
  logic [7:0] first_byte;

  ////////////////////////////////////////////////////////////////////////////
  // Line synchroniser and condition detector

  // Bus lines pass two flip-flops before any decision
  bus_line_sync u_sync (
    .clk(clk),
    .sys_rst(sys_rst),
    .scl_pin(serial_bus_clock_pin),
    .sda_pin(serial_bus_data_pin_in),
    .ev(ev)
  );

  ////////////////////////////////////////////////////////////////////////////
  // Register bank

  // Holds the control bytes and drives the configuration outputs
  config_bank #(
    .ID_BYTE(ID_BYTE)
  ) u_bank (
    .clk(clk),
    .sys_rst(sys_rst),
    .wr(q.wr),
    .bank(bank),
    .out1_en(clock_out1_enable),
    .out2_en(clock_out2_enable),
    .ss_en(spread_enable),
    .ss_depth(spread_depth_sel),
    .test_mode(test_mode_enable),
    .test_sel(test_ref_select)
  );

  ////////////////////////////////////////////////////////////////////////////
  // Readback byte selection

  // Unimplemented offsets read as zero
  function automatic logic [7:0] read_byte(input logic [4:0] p,
                                           input reg_bank_t b);
    logic [7:0] r;
    r = 8'h00;
    if (p < 5'(NUM_BYTES)) begin
      r = b[p[2:0]];
    end
    return r;
  endfunction

  // Count phase keeps the pointer, data phase steps it
  always_comb begin
    next_ptr = q.ptr;
    if (!q.count_phase && (q.ptr != 5'h1F)) begin
      next_ptr = q.ptr + 5'h01;
    end
    tx_byte = read_byte(next_ptr, bank);
    // Block reads open with the byte count, single reads with the byte
    if (q.count_phase) begin
      first_byte = BLOCK_COUNT;
    end else begin
      first_byte = read_byte(q.ptr, bank);
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Protocol state machine

  // One combinational pass over the slave state
  always_comb begin
    d = q;
    d.wr.en = 1'b0;
    if (ev.stop) begin
      // Stop ends any transfer; completed bytes stay written
      d.st = ST_IDLE;
      d.oe = 1'b0;
      d.busy = 1'b0;
    end else if (ev.start) begin
      // Start or repeated start: expect an address byte
      d.st = ST_ADDR;
      d.bitcnt = 4'h0;
      d.oe = 1'b0;
      d.busy = 1'b1;
    end else begin
      unique case (q.st)
        // Waiting for a start condition
        ST_IDLE: begin
        end
        // Not addressed, or read not acknowledged: line released until the next start
        ST_IGNORE: begin
          d.oe = 1'b0;
        end
        // Receiving an eight-bit byte, MSB first
        ST_ADDR, ST_CMD, ST_WDATA: begin
          if (ev.scl_rise && (q.bitcnt < 4'h8)) begin
            d.shift = {q.shift[6:0], ev.sda};
            d.bitcnt = q.bitcnt + 4'h1;
          end
          if (ev.scl_fall && (q.bitcnt == 4'h8)) begin
            d.bitcnt = 4'h0;
            unique case (q.st)
              // Address byte: match own address and take direction
              ST_ADDR: begin
                if (q.shift[7:1] == SLAVE_ADDR7) begin
                  d.rw = q.shift[0];
                  d.oe = 1'b1;
                  d.st = ST_ADDR_ACK;
                end else begin
                  d.st = ST_IGNORE;
                end
              end
              // Command byte: mode, chip select and offset
              ST_CMD: begin
                if (q.shift[CMD_CS_HI:CMD_CS_LO] == CHIP_SEL_VALUE) begin
                  d.block = ~q.shift[CMD_MODE_BIT];
                  if (q.shift[CMD_MODE_BIT]) begin
                    d.ptr = q.shift[CMD_OFS_HI:CMD_OFS_LO];
                    d.count_phase = 1'b0;
                  end else begin
                    // Block transfers always begin at offset zero
                    d.ptr = 5'h00;
                    d.count_phase = 1'b1;
                  end
                  d.oe = 1'b1;
                  d.st = ST_CMD_ACK;
                end else begin
                  // Another chip select: leave the bus alone
                  d.st = ST_IGNORE;
                end
              end
              // Data byte of a write
              default: begin
                if (q.count_phase) begin
                  // Byte count is taken but not used
                  d.count_phase = 1'b0;
                end else begin
                  d.wr.en = (q.ptr < 5'(NUM_BYTES));
                  d.wr.idx = q.ptr[2:0];
                  d.wr.data = q.shift;
                  if (q.ptr != 5'h1F) begin
                    d.ptr = q.ptr + 5'h01;
                  end
                end
                d.oe = 1'b1;
                d.st = ST_WDATA_ACK;
              end
            endcase
          end
        end
        // Address acknowledged: turn to write or read
        ST_ADDR_ACK: begin
          if (ev.scl_fall) begin
            if (q.rw) begin
              // First read byte is the count in a block read
              d.shift = first_byte;
              // Bit 7 goes out at once: pull low for a zero
              d.oe = ~first_byte[7];
              d.st = ST_RDATA;
            end else begin
              d.oe = 1'b0;
              d.st = ST_CMD;
            end
          end
        end
        // Command or data acknowledged: next byte is data
        ST_CMD_ACK, ST_WDATA_ACK: begin
          if (ev.scl_fall) begin
            d.oe = 1'b0;
            d.st = ST_WDATA;
          end
        end
        // Shifting a byte out, next bit placed on each falling edge
        ST_RDATA: begin
          if (ev.scl_fall) begin
            if (q.bitcnt == 4'h7) begin
              d.oe = 1'b0;
              d.st = ST_RACK;
            end else begin
              d.shift = {q.shift[6:0], 1'b0};
              d.bitcnt = q.bitcnt + 4'h1;
              d.oe = ~q.shift[6];
            end
          end
        end
        // Sampling the controller's acknowledge
        ST_RACK: begin
          if (ev.scl_rise) begin
            if (ev.sda) begin
              // Not acknowledged: last byte, wait for stop
              d.st = ST_IGNORE;
            end else begin
              d.st = ST_RNEXT;
            end
          end
        end
        // Acknowledged: load and present the following byte
        ST_RNEXT: begin
          if (ev.scl_fall) begin
            d.ptr = next_ptr;
            d.count_phase = 1'b0;
            d.shift = tx_byte;
            d.bitcnt = 4'h0;
            d.oe = ~tx_byte[7];
            d.st = ST_RDATA;
          end
        end
      endcase
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // State register

  // Whole slave state in one register
  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      q <= '{st: ST_IDLE, default: '0};
    end else begin
      q <= d;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Outputs

  // Open-drain data line: only ever pulled low
  assign serial_bus_data_pin_out = 1'b0;
  // Pull-down enable straight from the state register
  assign serial_bus_data_pin_oe = q.oe;
  // Transfer in progress between start and stop
  assign port_busy = q.busy;

endmodule

`default_nettype wire

// File: bus_master_model.sv
`timescale 1ns/1ps
`default_nettype none

// Two-wire bus controller; open drain, so it only ever pulls data low
module bus_master_model (
  input wire logic clk,
  output logic scl,
  output logic sda_low,
  input wire logic sda
);
  // Bus idles with both lines released high
  initial begin
    scl = 1'b1;
    sda_low = 1'b0;
  end

  ////////////////////////////////////////////////////////////////////////////
  // Conditions

  // Start or repeated start: data falls while the clock is high
  // The clock stays low until the slave has let go of an acknowledge
  task automatic start();
    @(posedge clk);
    #1 sda_low = 1'b0;
    #250 scl = 1'b1;
    #200 sda_low = 1'b1;
    #200 scl = 1'b0;
  endtask

  // Stop: data rises while the clock is high, then the clock stands still
  task automatic stop();
    #50 sda_low = 1'b1;
    #250 scl = 1'b1;
    #200 sda_low = 1'b0;
    #400;
  endtask

  ////////////////////////////////////////////////////////////////////////////
  // Bits and bytes

  // Data changes only while the clock is low; sampled mid-way through the high phase
  task automatic bit_io(input logic b, output logic r);
    #50 sda_low = ~b;
    #250 scl = 1'b1;
    #50 r = sda;
    #50 scl = 1'b0;
  endtask

  // Eight bits MSB first, then the ninth bit; m_ack high releases it
  task automatic byte_io(input logic [7:0] d, input logic m_ack,
                         output logic [7:0] q, output logic ack);
    for (int i = 7; i >= 0; i--) begin
      bit_io(d[i], q[i]);
    end
    bit_io(m_ack, ack);
  endtask
endmodule

`default_nettype wire

// File: cfg_port_sva.sv
`timescale 1ns/1ps
`default_nettype none

// Port-level checks of the serial configuration slave
module cfg_port_sva (
  input wire logic clk,
  input wire logic sys_rst,
  input wire logic serial_bus_clock_pin,
  input wire logic serial_bus_data_pin_in,
  input wire logic serial_bus_data_pin_out,
  input wire logic serial_bus_data_pin_oe,
  input wire logic clock_out1_enable,
  input wire logic clock_out2_enable,
  input wire logic spread_enable,
  input wire logic spread_depth_sel,
  input wire logic test_mode_enable,
  input wire logic test_ref_select,
  input wire logic port_busy
);
  default clocking @(posedge clk); endclocking
  default disable iff (sys_rst);

  logic scl_q; // Bus clock one cycle ago
  logic [3:0] rises_q; // Bus clock rises seen in this frame
  logic [3:0] rises_d;
  logic [5:0] cfg; // All configuration outputs together

  assign cfg = {clock_out1_enable, clock_out2_enable, spread_enable,
                spread_depth_sel, test_mode_enable, test_ref_select};

  // Count bus clock rises from the start of a frame, saturating
  always_comb begin
    rises_d = rises_q;
    if (!port_busy) begin
      rises_d = 4'h0;
    end else if (serial_bus_clock_pin && !scl_q && rises_q != 4'hF) begin
      rises_d = rises_q + 4'h1;
    end
  end

  // Helper registers
  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      scl_q <= 1'b1;
      rises_q <= 4'h0;
    end else begin
      scl_q <= serial_bus_clock_pin;
      rises_q <= rises_d;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Bus conditions

  sequence start_seen;
    $fell(serial_bus_data_pin_in) && serial_bus_clock_pin;
  endsequence

  sequence stop_seen;
    $rose(serial_bus_data_pin_in) && serial_bus_clock_pin;
  endsequence

  ////////////////////////////////////////////////////////////////////////////
  // Assertions

  a_start_busy: assert property (start_seen |-> ##[1:8] port_busy)
    else $error("busy not raised after start");
  a_stop_idle: assert property (stop_seen |-> ##[1:8] !port_busy)
    else $error("busy not dropped after stop");
  a_oe_busy: assert property (serial_bus_data_pin_oe |-> port_busy)
    else $error("data line driven outside a frame");
  a_oe_scl_low: assert property (
    $changed(serial_bus_data_pin_oe) |-> !serial_bus_clock_pin)
    else $error("data drive changed while bus clock high");
  a_ack_holds: assert property (
    $rose(serial_bus_data_pin_oe) |=> serial_bus_data_pin_oe [*5])
    else $error("data drive dropped within a bit");
  a_oe_after_addr: assert property (
    $rose(serial_bus_data_pin_oe) |-> rises_q >= 4'h8)
    else $error("data driven before a whole address byte");
  a_cfg_in_frame: assert property ($changed(cfg) |-> port_busy)
    else $error("configuration changed outside a frame");
  a_out_low: assert property (!serial_bus_data_pin_out)
    else $error("open drain value not low");
endmodule

bind serial_config_port cfg_port_sva u_sva (.clk(clk), .sys_rst(sys_rst),
  .serial_bus_clock_pin(serial_bus_clock_pin),
  .serial_bus_data_pin_in(serial_bus_data_pin_in),
  .serial_bus_data_pin_out(serial_bus_data_pin_out),
  .serial_bus_data_pin_oe(serial_bus_data_pin_oe),
  .clock_out1_enable(clock_out1_enable),
  .clock_out2_enable(clock_out2_enable), .spread_enable(spread_enable),
  .spread_depth_sel(spread_depth_sel), .test_mode_enable(test_mode_enable),
  .test_ref_select(test_ref_select), .port_busy(port_busy));

`default_nettype wire

// File: testbench.sv
`timescale 1ns/1ps
`default_nettype none

module testbench;
  localparam logic [7:0] ID_VAL = 8'hA5; // Identity byte, arbitrary
  localparam logic [7:0] DFLT [8] = '{8'h7C, 8'h00, 8'hEA, 8'hAF,
                                      8'h01, 8'h00, 8'h13, ID_VAL};
  logic clk = 1'b0;
  logic sys_rst = 1'b1;
  logic scl, sda_low, sda_w, dout, oe, busy, o1, o2, ss, dep, tm, ts;
  int failures = 0;
  int tests_run = 0;

  // Own clock of the design, 20 MHz
  always #25 clk = ~clk;
  // Pulled-up data wire, low when either party pulls it
  assign sda_w = !(sda_low || (oe && !dout));

  bus_master_model m (.clk(clk), .scl(scl), .sda_low(sda_low), .sda(sda_w));
  serial_config_port #(.ID_BYTE(ID_VAL)) dut (.clk(clk), .sys_rst(sys_rst),
    .serial_bus_clock_pin(scl), .serial_bus_data_pin_in(sda_w),
    .serial_bus_data_pin_out(dout), .serial_bus_data_pin_oe(oe),
    .clock_out1_enable(o1), .clock_out2_enable(o2), .spread_enable(ss),
    .spread_depth_sel(dep), .test_mode_enable(tm), .test_ref_select(ts),
    .port_busy(busy));

  ////////////////////////////////////////////////////////////////////////////
  // Compare and report

  task automatic chk_bit(input logic got, input logic exp);
    tests_run++;
    if (got !== exp) begin
      failures++;
      $display("[FAIL] %0t bit got %b expected %b", $time, got, exp);
    end
  endtask

  task automatic chk_byte(input logic [7:0] got, input logic [7:0] exp);
    tests_run++;
    if (got !== exp) begin
      failures++;
      $display("[FAIL] %0t byte got %h expected %h", $time, got, exp);
    end
  endtask

  task automatic print_verdict();
    $display("checks %0d failures %0d", tests_run, failures);
    if (failures == 0 && tests_run > 0) begin
      $display("Run complete: PASS");
    end else begin
      $display("Run complete: FAIL");
    end
    $finish;
  endtask

  ////////////////////////////////////////////////////////////////////////////
  // Transfers

  // Send a byte and judge the ninth bit (0 means acknowledged)
  task automatic send(input logic [7:0] d, input logic exp_ack);
    logic [7:0] q;
    logic a;
    m.byte_io(d, 1'b1, q, a);
    chk_bit(a, exp_ack);
  endtask

  // Take a byte from the slave and judge it
  task automatic recv(input logic nack, input logic [7:0] exp);
    logic [7:0] q;
    logic a;
    m.byte_io(8'hFF, nack, q, a);
    chk_byte(q, exp);
  endtask

  task automatic cmd_phase(input logic [7:0] cmd);
    m.start();
    send(8'hD2, 1'b0);
    send(cmd, 1'b0);
  endtask

  task automatic wr1(input logic [4:0] ofs, input logic [7:0] d);
    cmd_phase({3'b100, ofs});
    send(d, 1'b0);
    m.stop();
  endtask

  task automatic rd1(input logic [4:0] ofs, input logic [7:0] exp);
    cmd_phase({3'b100, ofs});
    m.start();
    send(8'hD3, 1'b0);
    recv(1'b1, exp);
    m.stop();
  endtask

  // Block read of the count and then n bytes, last one unacknowledged
  task automatic rd_block(input int n, input logic [7:0] exp [8]);
    cmd_phase(8'h00);
    m.start();
    send(8'hD3, 1'b0);
    recv(1'b0, 8'h08);
    for (int i = 0; i < n; i++) begin
      recv(i == n - 1, exp[i]);
    end
    m.stop();
  endtask

  ////////////////////////////////////////////////////////////////////////////
  // Scenarios

  task automatic t_defaults();
    chk_bit(o1, 1'b1);
    chk_bit(o2, 1'b1);
    chk_bit(ss, 1'b0);
    chk_bit(dep, 1'b1);
    chk_bit(tm, 1'b0);
    chk_bit(ts, 1'b0);
    rd_block(8, DFLT);
  endtask

  task automatic t_single();
    wr1(5'd2, 8'h04);
    chk_bit(ss, 1'b1);
    chk_bit(dep, 1'b0);
    rd1(5'd2, 8'h04);
    wr1(5'd0, 8'h08);
    chk_bit(o1, 1'b1);
    chk_bit(o2, 1'b0);
    wr1(5'd0, 8'h10);
    chk_bit(o1, 1'b0);
    chk_bit(o2, 1'b1);
    wr1(5'd6, 8'hC0);
    chk_bit(tm, 1'b1);
    chk_bit(ts, 1'b1);
    wr1(5'd7, 8'h00);
    rd1(5'd7, ID_VAL);
    rd1(5'd9, 8'h00);
  endtask

  // Count byte says five, only three follow before stop
  task automatic t_block();
    logic [7:0] exp [8];
    exp = '{8'h18, 8'h00, 8'hEE, 8'hAF, 8'h00, 8'h00, 8'h00, 8'h00};
    cmd_phase(8'h00);
    send(8'h05, 1'b0);
    for (int i = 0; i < 3; i++) begin
      send(exp[i], 1'b0);
    end
    m.stop();
    chk_bit(o1, 1'b1);
    chk_bit(o2, 1'b1);
    chk_bit(ss, 1'b1);
    chk_bit(dep, 1'b1);
    rd_block(4, exp);
  endtask

  // Foreign address and foreign chip select are left unanswered
  task automatic t_reject();
    m.start();
    send(8'hD4, 1'b1);
    send(8'h82, 1'b1);
    m.stop();
    m.start();
    send(8'hD2, 1'b0);
    send(8'hA2, 1'b1);
    send(8'h00, 1'b1);
    m.stop();
    chk_bit(busy, 1'b0);
    rd1(5'd2, 8'hEE);
  endtask

  ////////////////////////////////////////////////////////////////////////////
  // Main sequence and watchdog

  initial begin
    repeat (12) @(posedge clk);
    #1 sys_rst = 1'b0;
    repeat (4) @(posedge clk);
    t_defaults();
    // Settings are written after the defaults have been checked and read back
    t_single();
    t_block();
    t_reject();
    print_verdict();
  end

  initial begin
    #2000000;
    failures++;
    $display("[FAIL] %0t watchdog expired", $time);
    print_verdict();
  end
endmodule

`default_nettype wire
